// ==== hip_pkg.sv ====
// Purpose: Shared constants and types for the homing and interpolated position mode logic.
// Assumes: One 100 MHz control clock; all times handled in whole milliseconds.
// Notes:   Each figure below is named once and used by name in the design.
package hip_pkg;

  // Clock and time base.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int MS_IN_NS        = 1000000;
  localparam int CYCLES_PER_MS   = MS_IN_NS / CLK_PERIOD_NS;

  // Modes of operation codes.
  localparam logic signed [7:0] MODE_HOMING = 8'sh06;
  localparam logic signed [7:0] MODE_IP     = 8'sh07;

  // Controlword and statusword bit positions.
  localparam int CW_START_BIT   = 4;
  localparam int CW_HALT_BIT    = 8;
  localparam int SW_REACHED_BIT = 10;
  localparam int SW_ACTIVE_BIT  = 12;
  localparam int SW_ERROR_BIT   = 13;

  // Halt option code selecting the quick deceleration.
  localparam logic [2:0] HALT_OPT_QUICK = 3'h2;

  // Homing method code landmarks.
  localparam logic [7:0] METH_LIM_NEG    = 8'h01;
  localparam logic [7:0] METH_LIM_POS    = 8'h02;
  localparam logic [7:0] METH_HOME_FIRST = 8'h03;
  localparam logic [7:0] METH_HOME_RIGHT = 8'h05;
  localparam logic [7:0] METH_HOME_LAST  = 8'h06;
  localparam logic [7:0] METH_ANY_FIRST  = 8'h07;
  localparam logic [7:0] METH_ANY_POSEND = 8'h0a;
  localparam logic [7:0] METH_IDX_LAST   = 8'h0e;
  localparam logic [7:0] METH_NOIDX_OFS  = 8'h10;
  localparam logic [7:0] METH_NOIDX_LAST = 8'h1e;
  localparam logic [7:0] METH_NEXT_NEG   = 8'h21;
  localparam logic [7:0] METH_NEXT_POS   = 8'h22;
  localparam logic [7:0] METH_HERE       = 8'h23;

  // Reference sources.
  typedef enum logic [2:0] {
    SRC_LIMIT = 3'b000,
    SRC_HOME  = 3'b001,
    SRC_ANY   = 3'b010,
    SRC_INDEX = 3'b011,
    SRC_HERE  = 3'b100
  } hip_src_t;

  typedef struct packed {
    logic     valid;
    logic     useIndex;
    logic     onBlock;
    hip_src_t src;
    logic     dirPos;
    logic     edgeRight;
  } hip_method_t;

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_SEARCH = 3'b001,
    H_BLOCK  = 3'b010,
    H_INDEX  = 3'b011,
    H_DONE   = 3'b100
  } hip_home_state_t;

endpackage

// ==== hip_mode_ctrl.sv ====
// Purpose: Homing method sequencing and interpolated position mode of a motor drive.
// Assumes: All inputs are synchronous to core_clk; objects arrive as plain ports.
// Notes:   Travel profiles are reduced to direction, speed select and reference events.
`timescale 1ns/1ns

module hip_mode_ctrl
  import hip_pkg::*;
#(
  parameter int POS_W     = 32,
  parameter int MS_CYCLES = CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  // Drive state
  input  wire logic signed [7:0]       modeOfOperation,
  input  wire logic [15:0]             controlWord,
  input  wire logic                    operationEnabled,
  input  wire logic                    closedLoop,
  input  wire logic                    nmtOperational,
  input  wire logic                    syncPulse,
  // Homing configuration and sensors
  input  wire logic signed [7:0]       homingMethod,
  input  wire logic [15:0]             blockCurrentThreshold,
  input  wire logic [15:0]             blockDurationMs,
  input  wire logic [15:0]             motorCurrent,
  input  wire logic                    limitNeg,
  input  wire logic                    limitPos,
  input  wire logic                    homeSwitch,
  input  wire logic                    indexPulse,
  // Interpolation objects
  input  wire logic signed [POS_W-1:0] ipTarget,
  input  wire logic                    ipTargetWrite,
  input  wire logic                    ipWriteEnable,
  input  wire logic [15:0]             ipPeriodMs,
  input  wire logic [POS_W-1:0]        maxProfileVelocity,
  input  wire logic [POS_W-1:0]        maxMotorSpeed,
  input  wire logic [POS_W-1:0]        profileAccel,
  input  wire logic [POS_W-1:0]        profileDecel,
  input  wire logic [POS_W-1:0]        quickDecel,
  input  wire logic [2:0]              haltOptionCode,
  input  wire logic signed [POS_W-1:0] actualPosition,
  input  wire logic [POS_W-1:0]        followErrWindow,
  input  wire logic [15:0]             followErrTimeoutMs,
  // Status and commands
  output logic [15:0]                  statusWord,
  output logic signed [POS_W-1:0]      demandPosition,
  output logic [POS_W-1:0]             ipSpeed,
  output logic                         homeDrive,
  output logic                         homeDirPos,
  output logic                         homeZeroSpeed,
  output logic                         homeSetRef,
  output logic                         interpolationActiveFlag
);

  initial begin
    if (POS_W < 8 || MS_CYCLES < 1) begin
      $error("hip_mode_ctrl: unsupported parameter values");
    end
  end

  function automatic hip_method_t decodeMethod(input logic signed [7:0] m);
    hip_method_t d;
    logic [7:0]  a;
    logic [7:0]  b;
    d = '0;
    a = m[7] ? 8'(-m) : 8'(m);
    b = (a > METH_NOIDX_OFS && a <= METH_NOIDX_LAST) ? 8'(a - METH_NOIDX_OFS) : a;
    d.onBlock  = m[7];
    d.useIndex = (a <= METH_IDX_LAST) || a == METH_NEXT_NEG || a == METH_NEXT_POS;
    if (b == METH_LIM_NEG || b == METH_LIM_POS) begin
      d.valid  = 1'b1;
      d.src    = SRC_LIMIT;
      d.dirPos = (b == METH_LIM_POS);
    end else if (b >= METH_HOME_FIRST && b <= METH_HOME_LAST) begin
      d.valid     = !m[7];
      d.src       = SRC_HOME;
      d.edgeRight = (b >= METH_HOME_RIGHT);
      d.dirPos    = (b == METH_HOME_FIRST) || (b == METH_HOME_LAST);
    end else if (b >= METH_ANY_FIRST && b <= METH_IDX_LAST) begin
      d.valid     = 1'b1;
      d.src       = SRC_ANY;
      d.dirPos    = (b <= METH_ANY_POSEND);
      d.edgeRight = (b[1] ^ b[0]) ? (b <= METH_ANY_POSEND) : (b > METH_ANY_POSEND);
    end else if (a == METH_NEXT_NEG || a == METH_NEXT_POS) begin
      d.valid  = !m[7];
      d.src    = SRC_INDEX;
      d.dirPos = (a == METH_NEXT_POS);
    end else if (a == METH_HERE) begin
      d.valid    = !m[7];
      d.src      = SRC_HERE;
      d.useIndex = 1'b0;
    end
    if (a == 8'h00 || a > METH_HERE) begin
      d.valid = 1'b0;
    end
    return d;
  endfunction

  function automatic logic [POS_W-1:0] absDiff(input logic signed [POS_W-1:0] x,
                                               input logic signed [POS_W-1:0] y);
    logic signed [POS_W-1:0] dv;
    dv = x - y;
    return dv[POS_W-1] ? POS_W'(-dv) : POS_W'(dv);
  endfunction

  function automatic logic [POS_W-1:0] minOf(input logic [POS_W-1:0] x,
                                             input logic [POS_W-1:0] y);
    return (x < y) ? x : y;
  endfunction

  // Millisecond time base shared by block hold, ramps and timeouts.
  logic [$clog2(MS_CYCLES+1)-1:0] msCount_reg;
  logic                           msTick;

  assign msTick = (msCount_reg == ($clog2(MS_CYCLES+1))'(MS_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msCount_reg <= '0;
    end else if (msTick) begin
      msCount_reg <= '0;
    end else begin
      msCount_reg <= msCount_reg + 1'b1;
    end
  end

  // Homing sequencer.
  hip_home_state_t homeState_reg;
  hip_method_t     method_reg;
  hip_method_t     newMethod;
  logic            startBit;
  logic            startBitPrev_reg;
  logic            homeSwPrev_reg;
  logic            homeStart;
  logic            homeEdge;
  logic            wallHit;
  logic            homed_reg;
  logic [15:0]     blockMs_reg;

  assign newMethod = decodeMethod(homingMethod);
  assign startBit  = controlWord[CW_START_BIT];
  // A rising start bit only launches a known method with its preconditions met.
  assign homeStart = (modeOfOperation == MODE_HOMING) && startBit && !startBitPrev_reg
                     && newMethod.valid
                     && (operationEnabled || newMethod.src == SRC_HERE)
                     && (!newMethod.onBlock || closedLoop);
  // Moving positive, a left edge is a rising switch and a right edge a falling one.
  assign homeEdge  = (homeDirPos ^ method_reg.edgeRight) ? (homeSwitch && !homeSwPrev_reg)
                                                         : (!homeSwitch && homeSwPrev_reg);
  // A block stands in for the limit switch in the direction of travel.
  assign wallHit   = method_reg.onBlock ? (motorCurrent > blockCurrentThreshold)
                                        : (homeDirPos ? limitPos : limitNeg);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      startBitPrev_reg <= 1'b0;
      homeSwPrev_reg   <= 1'b0;
    end else begin
      startBitPrev_reg <= startBit;
      homeSwPrev_reg   <= homeSwitch;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      homeState_reg <= H_IDLE;
      method_reg    <= '0;
      homeDrive     <= 1'b0;
      homeDirPos    <= 1'b0;
      homeZeroSpeed <= 1'b0;
      homeSetRef    <= 1'b0;
      homed_reg     <= 1'b0;
      blockMs_reg   <= '0;
    end else begin
      homeSetRef <= 1'b0;
      if (modeOfOperation != MODE_HOMING || !startBit) begin
        homeState_reg <= (homeState_reg == H_DONE) ? H_DONE : H_IDLE;
        homeDrive     <= 1'b0;
        if (!startBit) begin
          homeState_reg <= H_IDLE;
        end
      end else begin
        unique case (homeState_reg)
          H_IDLE: begin
            if (homeStart) begin
              method_reg    <= newMethod;
              homeDirPos    <= newMethod.dirPos;
              homed_reg     <= 1'b0;
              homeZeroSpeed <= (newMethod.src == SRC_INDEX);
              if (newMethod.src == SRC_HERE) begin
                homeSetRef    <= 1'b1;
                homed_reg     <= 1'b1;
                homeState_reg <= H_DONE;
              end else if (newMethod.src == SRC_INDEX) begin
                homeDrive     <= 1'b1;
                homeState_reg <= H_INDEX;
              end else begin
                homeDrive     <= 1'b1;
                homeState_reg <= H_SEARCH;
              end
            end
          end
          H_SEARCH: begin
            if (method_reg.src == SRC_LIMIT && wallHit) begin
              if (method_reg.onBlock) begin
                blockMs_reg   <= '0;
                homeState_reg <= H_BLOCK;
              end else begin
                homeDirPos    <= !homeDirPos;
                homeZeroSpeed <= 1'b1;
                homeState_reg <= method_reg.useIndex ? H_INDEX : H_DONE;
                homeSetRef    <= !method_reg.useIndex;
                homed_reg     <= !method_reg.useIndex;
                homeDrive     <= method_reg.useIndex;
              end
            end else if (method_reg.src != SRC_LIMIT && homeEdge) begin
              homeZeroSpeed <= 1'b1;
              homeState_reg <= method_reg.useIndex ? H_INDEX : H_DONE;
              homeSetRef    <= !method_reg.useIndex;
              homed_reg     <= !method_reg.useIndex;
              homeDrive     <= method_reg.useIndex;
            end else if (method_reg.src == SRC_ANY && wallHit) begin
              homeDirPos <= !homeDirPos;
            end
          end
          H_BLOCK: begin
            if (msTick) begin
              blockMs_reg <= blockMs_reg + 16'h0001;
            end
            if (msTick && blockMs_reg + 16'h0001 >= blockDurationMs) begin
              homeDirPos    <= !homeDirPos;
              homeZeroSpeed <= 1'b1;
              homeState_reg <= method_reg.useIndex ? H_INDEX : H_DONE;
              homeSetRef    <= !method_reg.useIndex;
              homed_reg     <= !method_reg.useIndex;
              homeDrive     <= method_reg.useIndex;
            end
          end
          H_INDEX: begin
            if (indexPulse) begin
              homeSetRef    <= 1'b1;
              homed_reg     <= 1'b1;
              homeDrive     <= 1'b0;
              homeState_reg <= H_DONE;
            end
          end
          H_DONE: begin
            homeDrive <= 1'b0;
          end
          default: begin
            homeState_reg <= H_IDLE;
          end
        endcase
      end
    end
  end

  // Interpolated position mode.
  logic                    ipMode;
  logic                    syncLocked_reg;
  logic                    haltBit;
  logic signed [POS_W-1:0] target_reg;
  logic [POS_W-1:0]        stepSize_reg;
  logic [POS_W-1:0]        speedLimit;
  logic [POS_W-1:0]        speedGoal;
  logic [POS_W-1:0]        brakeRate;
  logic [POS_W-1:0]        remaining;
  logic [15:0]             ferrMs_reg;
  logic                    ferrFlag_reg;

  assign ipMode     = (modeOfOperation == MODE_IP);
  assign haltBit    = controlWord[CW_HALT_BIT];
  assign remaining  = absDiff(target_reg, demandPosition);
  assign speedLimit = closedLoop ? minOf(maxProfileVelocity, maxMotorSpeed)
                                 : maxProfileVelocity;
  assign speedGoal  = haltBit ? '0 : minOf(stepSize_reg, speedLimit);
  assign brakeRate  = (haltOptionCode == HALT_OPT_QUICK) ? quickDecel : profileDecel;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncLocked_reg <= 1'b0;
    end else if (!nmtOperational) begin
      syncLocked_reg <= 1'b0;
    end else if (syncPulse) begin
      syncLocked_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      interpolationActiveFlag <= 1'b0;
    end else begin
      interpolationActiveFlag <= ipMode && controlWord[CW_START_BIT]
                                 && syncLocked_reg && operationEnabled;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      target_reg   <= '0;
      stepSize_reg <= '0;
    end else if (!ipMode) begin
      target_reg   <= actualPosition;
      stepSize_reg <= '0;
    end else if (ipTargetWrite && ipWriteEnable) begin
      // One division per target; the demand then advances ipSpeed per millisecond, ramped toward that step within the speed limit.
      target_reg   <= ipTarget;
      stepSize_reg <= (ipPeriodMs == 16'h0000) ? absDiff(ipTarget, demandPosition)
                      : POS_W'(absDiff(ipTarget, demandPosition) / ipPeriodMs);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ipSpeed <= '0;
    end else if (!interpolationActiveFlag) begin
      ipSpeed <= '0;
    end else if (msTick) begin
      if (ipSpeed > speedGoal) begin
        ipSpeed <= (ipSpeed - speedGoal > brakeRate) ? POS_W'(ipSpeed - brakeRate) : speedGoal;
      end else if (ipSpeed < speedGoal) begin
        ipSpeed <= (speedGoal - ipSpeed > profileAccel) ? POS_W'(ipSpeed + profileAccel)
                                                        : speedGoal;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      demandPosition <= '0;
    end else if (!interpolationActiveFlag) begin
      demandPosition <= actualPosition;
    end else if (msTick) begin
      if (remaining <= ipSpeed) begin
        demandPosition <= target_reg;
      end else if (target_reg > demandPosition) begin
        demandPosition <= demandPosition + $signed(ipSpeed);
      end else begin
        demandPosition <= demandPosition - $signed(ipSpeed);
      end
    end
  end

  // Following error: the corridor must be left for longer than the timeout.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ferrMs_reg   <= '0;
      ferrFlag_reg <= 1'b0;
    end else if (!closedLoop || !interpolationActiveFlag) begin
      ferrMs_reg   <= '0;
      ferrFlag_reg <= 1'b0;
    end else if (absDiff(demandPosition, actualPosition) <= followErrWindow) begin
      ferrMs_reg <= '0;
    end else if (msTick) begin
      if (ferrMs_reg >= followErrTimeoutMs) begin
        ferrFlag_reg <= 1'b1;
      end else begin
        ferrMs_reg <= ferrMs_reg + 16'h0001;
      end
    end
  end

  // Statusword bits owned by this block; other bits read as zero.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusWord <= '0;
    end else begin
      statusWord <= '0;
      if (ipMode) begin
        statusWord[SW_REACHED_BIT] <= haltBit ? (ipSpeed == '0)
                                              : (demandPosition == target_reg);
        statusWord[SW_ACTIVE_BIT]  <= interpolationActiveFlag;
        statusWord[SW_ERROR_BIT]   <= ferrFlag_reg;
      end else if (modeOfOperation == MODE_HOMING) begin
        statusWord[SW_REACHED_BIT] <= (homeState_reg == H_IDLE) || (homeState_reg == H_DONE);
        statusWord[SW_ACTIVE_BIT]  <= homed_reg;
      end
    end
  end

endmodule

// ==== hip_mode_checker.sv ====
// Purpose: Port-level checks of the homing and interpolation logic.
// Assumes: One clock domain, reset active low.
// Notes:   Bound to the design from the bench top file.
`timescale 1ns/1ns
module hip_mode_checker
  import hip_pkg::*;
#(
  parameter int POS_W = 32
) (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  // Watched inputs
  input wire logic signed [7:0]       modeOfOperation,
  input wire logic [15:0]             controlWord,
  input wire logic                    operationEnabled,
  input wire logic                    closedLoop,
  input wire logic signed [7:0]       homingMethod,
  input wire logic                    limitNeg,
  input wire logic [POS_W-1:0]        maxProfileVelocity,
  input wire logic [POS_W-1:0]        maxMotorSpeed,
  // Watched outputs
  input wire logic [POS_W-1:0]        ipSpeed,
  input wire logic                    homeDrive,
  input wire logic                    homeDirPos,
  input wire logic                    homeSetRef,
  input wire logic                    interpolationActiveFlag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence homeStart;
    $rose(controlWord[CW_START_BIT]) && modeOfOperation == MODE_HOMING;
  endsequence
  here_ref_a: assert property (homeStart ##0 homingMethod == 8'sd35
    |=> homeSetRef && !homeDrive) else $error("method 35 gave no reference pulse");
  bad_code_a: assert property (homeStart ##0 homingMethod inside {0, 15, 16, 31, 32}
    |=> !homeDrive && !homeSetRef) else $error("unsupported method started");
  block_loop_a: assert property (homeStart ##0 homingMethod < 0 && !closedLoop
    |=> !homeDrive) else $error("block homing started in open loop");
  lim_start_a: assert property (homeStart ##0 homingMethod == 8'sd17 && operationEnabled
    |=> homeDrive && !homeDirPos) else $error("method 17 did not search negative");
  lim_ref_a: assert property (homeDrive && !homeDirPos && limitNeg && controlWord[4]
    && homingMethod == 8'sd17 |=> homeSetRef && !homeDrive) else $error("no reference");
  abort_a: assert property (homeDrive && !controlWord[CW_START_BIT] |=> !homeDrive)
    else $error("homing not aborted");
  ip_off_a: assert property (!controlWord[CW_START_BIT] || modeOfOperation != MODE_IP
    |=> !interpolationActiveFlag) else $error("interpolation active without request");
  speed_cap_a: assert property (interpolationActiveFlag && closedLoop
    |-> ipSpeed <= maxProfileVelocity && ipSpeed <= maxMotorSpeed) else $error("speed cap");
endmodule

// ==== hip_bus_master.sv ====
// Purpose: Behavioural higher-level controller feeding SYNC and targets.
// Assumes: Requests from the bench are one-cycle levels.
// Notes:   Target lines flip between writes so a stale value is never taken as fresh.
`timescale 1ns/1ns
module hip_bus_master
  import hip_pkg::*;
#(
  parameter int SYNC_CYC = 8
) (
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          rst_n,
  // Bench commands
  input wire logic          syncOn,
  input wire logic          sendReq,
  input wire logic [31:0]   sendVal,
  // Objects towards the drive
  output logic              syncPulse,
  output logic [31:0]       ipTarget,
  output logic              ipTargetWrite
);
  logic [7:0] syncCnt_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncCnt_reg <= 8'h00;
      syncPulse   <= 1'b0;
    end else begin
      syncCnt_reg <= (syncCnt_reg == 8'(SYNC_CYC - 1)) ? 8'h00 : syncCnt_reg + 8'h01;
      syncPulse   <= syncOn && syncCnt_reg == 8'h00;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ipTarget      <= 32'h0;
      ipTargetWrite <= 1'b0;
    end else begin
      ipTargetWrite <= sendReq;
      ipTarget      <= sendReq ? sendVal : ~ipTarget;
    end
  end
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the homing and interpolation logic.
// Assumes: Inputs change on the falling edge; the ms tick is shortened to 4 cycles.
// Notes:   The bus master model supplies SYNC and target writes.
`timescale 1ns/1ns
module tb
  import hip_pkg::*;
;
  localparam int MSC = 4;
  logic               core_clk = 1'b0, rst_n = 1'b0, homeSwitch = 1'b0, ipWriteEnable = 1'b0;
  logic signed [7:0]  modeOfOperation = 8'sh06, homingMethod = 8'sh00;
  logic [15:0]        controlWord = 16'h0000, motorCurrent = 16'h0000, statusWord;
  logic               operationEnabled = 1'b0, closedLoop = 1'b0, nmtOperational = 1'b0;
  logic               limitNeg = 1'b0, limitPos = 1'b0, indexPulse = 1'b0;
  logic               syncOn = 1'b0, sendReq = 1'b0, syncPulse, ipTargetWrite;
  logic [31:0]        sendVal = 32'h0, actualPosition = 32'h0, ipTarget, ipSpeed;
  logic [31:0]        followErrWindow = 32'h1000, demandPosition;
  logic [31:0]        maxProfileVelocity = 32'h8, maxMotorSpeed = 32'h5;
  logic [15:0]        blockDurationMs = 16'h0003, followErrTimeoutMs = 16'h0001;
  logic [2:0]         haltOptionCode = 3'h2;
  logic               homeDrive, homeDirPos, homeSetRef, interpolationActiveFlag, homeZeroSpeed;
  logic signed [7:0]  meth [4] = '{8'sd1, 8'sd2, 8'sd17, 8'sd18};
  logic signed [7:0]  bad [6] = '{8'sd0, 8'sd15, 8'sd32, 8'sd36, -8'sd3, -8'sd31};
  int                 mismatches = 0, compares = 0, cycles = 0, n;
  hip_bus_master master (.core_clk, .rst_n, .syncOn, .sendReq, .sendVal, .syncPulse,
    .ipTarget, .ipTargetWrite);
  hip_mode_ctrl #(.MS_CYCLES(MSC)) dut (.core_clk, .rst_n, .modeOfOperation, .controlWord,
    .operationEnabled, .closedLoop, .nmtOperational, .syncPulse, .homingMethod,
    .blockCurrentThreshold(16'h0100), .blockDurationMs, .motorCurrent,
    .limitNeg, .limitPos, .homeSwitch, .indexPulse, .ipTarget, .ipTargetWrite,
    .ipWriteEnable, .ipPeriodMs(16'h0001), .maxProfileVelocity,
    .maxMotorSpeed, .profileAccel(32'h100), .profileDecel(32'h1),
    .quickDecel(32'h2), .haltOptionCode, .actualPosition, .followErrWindow,
    .followErrTimeoutMs, .statusWord, .demandPosition, .ipSpeed, .homeDrive,
    .homeDirPos, .homeZeroSpeed, .homeSetRef, .interpolationActiveFlag);
  always #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic startHome(input logic signed [7:0] m);
    homingMethod = m;
    controlWord[4] = 1'b0;
    cyc(1);
    controlWord[4] = 1'b1;
    cyc(1);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    chk({statusWord, homeDrive, homeSetRef, interpolationActiveFlag}, 32'h2000);
    startHome(8'sd35);
    chk({homeSetRef, homeDrive}, 2'b10);
    operationEnabled = 1'b1;
    foreach (meth[i]) begin
      startHome(meth[i]);
      chk({homeDrive, homeDirPos, homeZeroSpeed}, {1'b1, ~meth[i][0], 1'b0});
      if (meth[i][0]) limitNeg = 1'b1; else limitPos = 1'b1;
      cyc(1);
      {limitNeg, limitPos} = 2'b00;
      if (meth[i] < 8'sd3) begin
        chk({homeDrive, homeDirPos, homeZeroSpeed}, {1'b1, meth[i][0], 1'b1});
        indexPulse = 1'b1;
        cyc(1);
        indexPulse = 1'b0;
      end
      chk(homeSetRef, 1'b1);
      cyc(1);
      chk(statusWord & 16'h3400, 16'h1400);
    end
    for (int m = 33; m < 35; m++) begin
      startHome(8'(m));
      chk({homeDrive, homeDirPos, homeZeroSpeed}, {1'b1, m == 34, 1'b1});
      indexPulse = 1'b1;
      cyc(1);
      indexPulse = 1'b0;
      chk(homeSetRef, 1'b1);
    end
    foreach (bad[i]) begin
      startHome(bad[i]);
      cyc(1);
      chk({homeDrive, statusWord[10]}, 2'b01);
    end
    startHome(-8'sd17);
    chk(homeDrive, 1'b0);
    closedLoop = 1'b1;
    startHome(-8'sd17);
    chk({homeDrive, homeDirPos}, 2'b10);
    motorCurrent = 16'h0200;
    n = 0;
    while (homeSetRef !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 2 * MSC && n <= 5 * MSC), 32'h1);
    motorCurrent = 16'h0000;
    startHome(8'sd3);
    controlWord[4] = 1'b0;
    cyc(1);
    chk(homeDrive, 1'b0);
    startHome(8'sd19);
    homeSwitch = 1'b1;
    cyc(1);
    homeSwitch = 1'b0;
    chk(homeSetRef, 1'b1);
    controlWord = 16'h0000;
    cyc(1);
    {modeOfOperation, nmtOperational, syncOn, ipWriteEnable} = {MODE_IP, 3'b111};
    controlWord[4] = 1'b1;
    n = 0;
    while (interpolationActiveFlag !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    cyc(1);
    chk({interpolationActiveFlag, statusWord[12]}, 2'b11);
    sendVal = 32'd40;
    for (int w = 0; w < 2; w++) begin
      sendReq = 1'b1;
      cyc(1);
      sendReq = 1'b0;
      cyc(3 * MSC);
      if (w == 0) chk(ipSpeed, 32'h5);
      n = 0;
      while (demandPosition !== 32'd40 && n < 100) begin
        cyc(1);
        n++;
      end
      chk(demandPosition, 32'd40);
      cyc(2);
      chk(statusWord & 16'h2400, 16'h0400);
      if (w == 0) {ipWriteEnable, sendVal} = {1'b0, 32'd100};
    end
    {ipWriteEnable, sendVal, sendReq} = {1'b1, 32'd200, 1'b1};
    cyc(1);
    sendReq = 1'b0;
    cyc(3 * MSC);
    controlWord[8] = 1'b1;
    cyc(2 * MSC);
    chk(ipSpeed, 32'h1);
    cyc(3 * MSC);
    chk(ipSpeed, 32'h0);
    chk(statusWord[10], 1'b1);
    followErrWindow = 32'h2;
    cyc(4 * MSC);
    chk(statusWord[13], 1'b1);
    closedLoop = 1'b0;
    cyc(3);
    chk(statusWord[13], 1'b0);
    controlWord[8] = 1'b0;
    cyc(2 * MSC);
    chk(ipSpeed, 32'h8);
    end_of_test();
  end
endmodule
bind hip_mode_ctrl hip_mode_checker #(.POS_W(POS_W)) checker_i (.core_clk, .rst_n,
  .modeOfOperation, .controlWord, .operationEnabled, .closedLoop, .homingMethod, .limitNeg,
  .maxProfileVelocity, .maxMotorSpeed, .ipSpeed, .homeDrive, .homeDirPos, .homeSetRef,
  .interpolationActiveFlag);
